// File: common/flash_crc_scanner_defs.svh
// Purpose : Named constants for the flash checksum scanner
// Assumes : Included by bare name from design files
// Notes   : Definitions only
`ifndef FLASH_CRC_SCANNER_DEFS_SVH
`define FLASH_CRC_SCANNER_DEFS_SVH

// ****************************************
// Section select encodings
// ****************************************
`define SEL_WHOLE_FLASH   2'h0
`define SEL_BOOT_APP      2'h1
`define SEL_BOOT_ONLY     2'h2
`define SEL_RESERVED      2'h3
`define SEL_RESET         2'h0

// ****************************************
// Start-up fuse field encodings
// ****************************************
`define BOOTSCAN_NONE     2'h0
`define BOOTSCAN_BOOT     2'h1
`define BOOTSCAN_BOOTAPP  2'h2
`define BOOTSCAN_FLASH    2'h3

// ****************************************
// Timing counts in clock cycles
// ****************************************
`define START_DELAY_CYC   2'h3
`define FETCH_CYC         2'h3
`define CNT_ONE           2'h1

// ****************************************
// Generator constants
// ****************************************
`define POLY16            32'h00001021
`define POLY32            32'h04C11DB7
`define CRC_PRESET        32'hFFFFFFFF
`define CRC16_MASK        32'h0000FFFF
`define CKSUM16_LAST_OFS  16'h0001
`define CKSUM32_LAST_OFS  16'h0003
`define ADDR_ZERO         16'h0000
`define ADDR_STEP         16'h0001

// ****************************************
// Reset values of status
// ****************************************
`define PASS_RESET        1'b1

`endif

// File: common/flash_crc_scanner_pkg.sv
// Purpose : Types shared by the flash checksum scanner
// Assumes : Nothing is imported; users write the package name
// Notes   : Constants live in the defs header
package flash_crc_scanner_pkg;

  // ****************************************
  // Scan sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    ST_STARTUP,
    ST_IDLE,
    ST_DELAY,
    ST_FETCH,
    ST_FEED
  } scan_state_type;

  // ****************************************
  // Non-volatile configuration
  // ****************************************
  typedef struct packed {
    logic        crc32_sel;                // 1 selects 32-bit checksum
    logic [1:0]  startup_scan_fuse_field;  // Start-up scan choice
    logic [15:0] boot_section_last_byte;   // Byte address
    logic [15:0] app_code_last_byte;       // Byte address
    logic [15:0] flash_last_byte;          // Byte address
  } fuse_cfg_type;

  // ****************************************
  // Write strobes of first control byte
  // ****************************************
  typedef struct packed {
    logic wr;          // Write strobe
    logic enable;      // Enable bit value
    logic nmi_enable;  // Failure interrupt enable value
    logic soft_reset;  // Scanner reset strobe
  } ctrl_write_type;

  // ****************************************
  // Observable status
  // ****************************************
  typedef struct packed {
    logic       enable;              // Enable bit
    logic       failure_nmi_enable;  // Interrupt enable bit
    logic [1:0] scan_section_select; // Section field
    logic       busy;                // Scan in progress
    logic       pass;                // Comparison outcome
  } scan_status_type;

endpackage

// File: logic/crc_byte_engine.sv
// Purpose : Byte-wide checksum accumulator, 16 or 32 bit
// Assumes : Bytes fed MSB first, one per cycle
// Notes   : Preset loads all ones over the full width
`timescale 1ns/1ps
`include "flash_crc_scanner_defs.svh"

module crc_byte_engine (
  input  wire logic        clk_i,     // Core clock
  input  wire logic        rst_i,     // Async reset, high
  input  wire logic        preset_i,  // Load all ones
  input  wire logic        feed_i,    // Absorb byte_i
  input  wire logic [7:0]  byte_i,    // Data byte
  input  wire logic        mode32_i,  // 1 selects 32-bit
  output logic      [31:0] crc_o      // Accumulator
);

  // ****************************************
  // One byte through the shift register
  // ****************************************
  function automatic logic [31:0] crc_step(input logic [31:0] c_in,
                                           input logic [7:0]  b,
                                           input logic        m32);
    logic [31:0] c;
    logic        fb;
    c = c_in;
    for (int i = 7; i >= 0; i--) begin
      // Feedback from top bit of active width
      fb = (m32 ? c[31] : c[15]) ^ b[i];
      c = {c[30:0], 1'b0};
      if (fb) begin
        c = c ^ (m32 ? `POLY32 : `POLY16);
      end
    end
    if (!m32) begin
      c = c & `CRC16_MASK;
    end
    return c;
  endfunction

  logic [31:0] crc_q;  // Accumulator register
  logic [31:0] crc_d;  // Next accumulator

  // Full-width preset, as width flag may lag at start-up
  assign crc_d = preset_i ? `CRC_PRESET :
                 feed_i   ? crc_step(crc_q, byte_i, mode32_i) :
                            crc_q;

  // Accumulator flop
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      crc_q <= `CRC_PRESET;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign crc_o = crc_q;

endmodule // crc_byte_engine

// File: logic/flash_crc_scanner.sv
// Purpose : Background flash checksum scanner with start-up gate
// Assumes : Fuse inputs are static and in the core clock domain
// Notes   : Summary of operation follows
// Summary of operation
// - Scan starts three cycles after enable write
// - Checksum width comes from fuse setting
// - Start-up scan gates CPU on failure
// - Pass: enable one, section shown, pass one
// - Fail: CPU hangs after start-up scan, enable one, pass zero
// - Scan owns flash and stalls CPU
// - Each 16-bit flash fetch takes three cycles
// - 16-bit polynomial x16+x12+x5+1
// - 32-bit mode uses Ethernet polynomial
// - Bytes from zero, MSB first, per byte
// - Accumulator preset to all ones
// - Region: whole, boot, or boot plus app
// - Pass only when stored checksum matches
// - Mismatch clears the pass flag
// - Interrupt enable set by one, reset clears
// - Failure with enable raises sticky NMI
// - NMI ignores global interrupt enable
// - Busy and pass status bits reported
// - Section codes 0 whole, 1 bootapp, 2 boot
// - Writing zero to enable does nothing
// - Section writes ignored when busy or NMI
// - Pass reads one before any scan
`timescale 1ns/1ps
`include "flash_crc_scanner_defs.svh"

module flash_crc_scanner (
  input  wire logic                                 CORE_CLK_I,   // 125 MHz core clock
  input  wire logic                                 RESET_I,      // Async system reset, high
  input  wire flash_crc_scanner_pkg::fuse_cfg_type  FUSE_CFG_I,   // Non-volatile settings
  input  wire flash_crc_scanner_pkg::ctrl_write_type CTRL_WR_I,   // First control byte write
  input  wire logic                                 SEL_WR_I,     // Section write strobe
  input  wire logic [1:0]                           SEL_VALUE_I,  // Section write value
  input  wire logic [15:0]                          FLASH_RDATA_I,// Flash read word
  output logic                                      FLASH_REQ_O,  // Scanner owns flash port
  output logic      [14:0]                          FLASH_ADDR_O, // Flash word address
  output logic                                      CPU_STALL_O,  // Stall CPU fetches
  output logic                                      CPU_RUN_O,    // CPU may execute code
  output logic                                      NMI_O,        // Sticky failure interrupt
  output flash_crc_scanner_pkg::scan_status_type    STATUS_O      // Status and control readback
);

  // ****************************************
  // State and registers
  // ****************************************
  flash_crc_scanner_pkg::scan_state_type state_q;  // Sequencer state
  flash_crc_scanner_pkg::scan_state_type state_d;  // Next state
  logic        enable_q;     // Enable bit
  logic        enable_d;     // Next enable
  logic        failure_nmi_enable_q;      // Failure interrupt enable
  logic        failure_nmi_enable_d;      // Next interrupt enable
  logic [1:0]  sel_q;        // Section select
  logic [1:0]  sel_d;        // Next section select
  logic        busy_q;       // Busy flag
  logic        busy_d;       // Next busy
  logic        pass_q;       // Pass flag
  logic        pass_d;       // Next pass
  logic        nmi_q;        // Interrupt request
  logic        nmi_d;        // Next interrupt request
  logic        run_q;        // CPU release
  logic        run_d;        // Next CPU release
  logic [1:0]  cnt_q;        // Delay and fetch counter
  logic [1:0]  cnt_d;        // Next counter
  logic [15:0] addr_q;       // Current byte address
  logic [15:0] addr_d;       // Next byte address
  logic [15:0] word_q;       // Fetched flash word
  logic [15:0] word_d;       // Next fetched word
  logic [31:0] stored_q;     // Collected stored checksum
  logic [31:0] stored_d;     // Next stored checksum
  logic        mode32_q;     // Width latched at scan start
  logic        mode32_d;     // Next width

  // ****************************************
  // Decoded control conditions
  // ****************************************
  logic        nmi_lock;     // Writes blocked after NMI
  logic        soft_rst;     // Accepted scanner reset
  logic        start_wr;     // Accepted enable write
  logic        sel_ok;       // Accepted section write
  logic        boot_scan;    // Start-up scan requested
  logic [1:0]  boot_sel;     // Section for start-up scan
  logic [15:0] sec_end;      // Last byte of section
  logic [15:0] ck_ofs;       // Checksum length minus one
  logic [15:0] data_lim;     // First checksum byte address
  logic        is_data;      // Byte goes to generator
  logic        last_byte;    // Final byte of section
  logic [7:0]  cur_byte;     // Byte picked from word
  logic        fetch_done;   // Fetch completes this cycle
  logic        feeding;      // A byte is processed
  logic        crc_preset;   // Preset generator
  logic [31:0] crc_val;      // Generator value
  logic [31:0] stored_nx;    // Stored sum incl. this byte
  logic        match;        // Computed equals stored
  logic        finish;       // Scan ends this cycle

  // Writes refused once an interrupt fired
  assign nmi_lock  = nmi_q;
  // Reset strobe limited while busy when NMI enabled
  assign soft_rst  = CTRL_WR_I.wr & CTRL_WR_I.soft_reset & ~nmi_lock & ~(failure_nmi_enable_q & busy_q);
  // Only a one on enable starts a check
  assign start_wr  = CTRL_WR_I.wr & CTRL_WR_I.enable & ~busy_q & ~nmi_lock & ~soft_rst;
  // Section accepted only when idle, unlocked, legal code
  assign sel_ok    = SEL_WR_I & ~busy_q & ~nmi_lock & (SEL_VALUE_I != `SEL_RESERVED);

  // Start-up fuse decoding
  assign boot_scan = FUSE_CFG_I.startup_scan_fuse_field != `BOOTSCAN_NONE;
  assign boot_sel  = (FUSE_CFG_I.startup_scan_fuse_field == `BOOTSCAN_BOOT)    ? `SEL_BOOT_ONLY :
                     (FUSE_CFG_I.startup_scan_fuse_field == `BOOTSCAN_BOOTAPP) ? `SEL_BOOT_APP  :
                                                                                 `SEL_WHOLE_FLASH;

  // Section end from selected region
  assign sec_end   = (sel_q == `SEL_BOOT_ONLY) ? FUSE_CFG_I.boot_section_last_byte :
                     (sel_q == `SEL_BOOT_APP)  ? FUSE_CFG_I.app_code_last_byte     :
                                                 FUSE_CFG_I.flash_last_byte;

  // Checksum occupies final two or four bytes
  assign ck_ofs    = mode32_q ? `CKSUM32_LAST_OFS : `CKSUM16_LAST_OFS;
  assign data_lim  = sec_end - ck_ofs;
  assign is_data   = addr_q < data_lim;
  assign last_byte = addr_q == sec_end;

  // Even address is low byte of the word
  assign cur_byte  = addr_q[0] ? word_q[15:8] : word_q[7:0];
  assign fetch_done = (state_q == flash_crc_scanner_pkg::ST_FETCH) && (cnt_q == `FETCH_CYC - `CNT_ONE);
  assign feeding   = state_q == flash_crc_scanner_pkg::ST_FEED;

  // Stored checksum assembly by width
  assign stored_nx = mode32_q ? {cur_byte, stored_q[31:8]} :
                                {16'h0000, stored_q[7:0], cur_byte};
  assign match     = mode32_q ? (stored_nx == crc_val) :
                                (stored_nx[15:0] == crc_val[15:0]);
  assign finish    = feeding & last_byte;

  // Generator preset throughout the delay and in the start-up state
  assign crc_preset = (state_q == flash_crc_scanner_pkg::ST_DELAY) ||
                      (state_q == flash_crc_scanner_pkg::ST_STARTUP);

  // ****************************************
  // Checksum generator
  // ****************************************
  crc_byte_engine u_crc (
    .clk_i    (CORE_CLK_I),
    .rst_i    (RESET_I),
    .preset_i (crc_preset),
    .feed_i   (feeding & is_data),
    .byte_i   (cur_byte),
    .mode32_i (mode32_q),
    .crc_o    (crc_val)
  );

  // ****************************************
  // Sequencer next state
  // ****************************************
  always_comb begin
    state_d  = state_q;
    enable_d = enable_q;
    failure_nmi_enable_d  = failure_nmi_enable_q;
    sel_d    = sel_q;
    busy_d   = busy_q;
    pass_d   = pass_q;
    nmi_d    = nmi_q;
    run_d    = run_q;
    cnt_d    = cnt_q;
    addr_d   = addr_q;
    word_d   = word_q;
    stored_d = stored_q;
    mode32_d = mode32_q;
    // Interrupt enable is set-only, idle only
    if (CTRL_WR_I.wr && CTRL_WR_I.nmi_enable && !busy_q && !nmi_lock) begin
      failure_nmi_enable_d = 1'b1;
    end
    // Section write when allowed
    if (sel_ok) begin
      sel_d = SEL_VALUE_I;
    end
    unique case (state_q)
      flash_crc_scanner_pkg::ST_STARTUP: begin
        // Width fixed by fuse, never a runtime bit
        mode32_d = FUSE_CFG_I.crc32_sel;
        addr_d   = `ADDR_ZERO;
        if (boot_scan) begin
          // Scan before the CPU is released
          enable_d = 1'b1;
          sel_d    = boot_sel;
          busy_d   = 1'b1;
          cnt_d    = 2'h0;
          state_d  = flash_crc_scanner_pkg::ST_FETCH;
        end else begin
          run_d   = 1'b1;
          state_d = flash_crc_scanner_pkg::ST_IDLE;
        end
      end
      flash_crc_scanner_pkg::ST_IDLE: begin
        if (start_wr) begin
          enable_d = 1'b1;
          busy_d   = 1'b1;
          cnt_d    = `CNT_ONE;
          mode32_d = FUSE_CFG_I.crc32_sel;
          state_d  = flash_crc_scanner_pkg::ST_DELAY;
        end
      end
      flash_crc_scanner_pkg::ST_DELAY: begin
        // CPU still runs while waiting
        addr_d = `ADDR_ZERO;
        if (cnt_q == `START_DELAY_CYC - `CNT_ONE) begin
          cnt_d   = 2'h0;
          state_d = flash_crc_scanner_pkg::ST_FETCH;
        end else begin
          cnt_d = cnt_q + `CNT_ONE;
        end
      end
      flash_crc_scanner_pkg::ST_FETCH: begin
        // Word read occupies three cycles
        if (fetch_done) begin
          word_d  = FLASH_RDATA_I;
          cnt_d   = 2'h0;
          state_d = flash_crc_scanner_pkg::ST_FEED;
        end else begin
          cnt_d = cnt_q + `CNT_ONE;
        end
      end
      flash_crc_scanner_pkg::ST_FEED: begin
        if (!is_data) begin
          stored_d = stored_nx;
        end
        if (finish) begin
          // Busy and pass change together
          busy_d  = 1'b0;
          pass_d  = match;
          if (match) begin
            run_d = 1'b1;
          end
          if (!match && failure_nmi_enable_q) begin
            nmi_d = 1'b1;
          end
          state_d = flash_crc_scanner_pkg::ST_IDLE;
        end else begin
          addr_d = addr_q + `ADDR_STEP;
          // Odd byte done means next word needed
          if (addr_q[0]) begin
            state_d = flash_crc_scanner_pkg::ST_FETCH;
          end
        end
      end
    endcase
    // Scanner reset clears enable, section and busy, and returns pass to one
    if (soft_rst && state_q != flash_crc_scanner_pkg::ST_STARTUP) begin
      enable_d = 1'b0;
      sel_d    = `SEL_RESET;
      busy_d   = 1'b0;
      pass_d   = `PASS_RESET;
      state_d  = flash_crc_scanner_pkg::ST_IDLE;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_q  <= flash_crc_scanner_pkg::ST_STARTUP;
      enable_q <= 1'b0;
      failure_nmi_enable_q  <= 1'b0;
      sel_q    <= `SEL_RESET;
      busy_q   <= 1'b0;
      pass_q   <= `PASS_RESET;
      nmi_q    <= 1'b0;
      run_q    <= 1'b0;
    end else begin
      state_q  <= state_d;
      enable_q <= enable_d;
      failure_nmi_enable_q  <= failure_nmi_enable_d;
      sel_q    <= sel_d;
      busy_q   <= busy_d;
      pass_q   <= pass_d;
      nmi_q    <= nmi_d;
      run_q    <= run_d;
    end
  end

  // ****************************************
  // Datapath registers
  // ****************************************
  always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      cnt_q    <= 2'h0;
      addr_q   <= `ADDR_ZERO;
      word_q   <= 16'h0000;
      stored_q <= 32'h00000000;
      mode32_q <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      addr_q   <= addr_d;
      word_q   <= word_d;
      stored_q <= stored_d;
      mode32_q <= mode32_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Flash priority held during fetch and feed
  assign FLASH_REQ_O  = (state_q == flash_crc_scanner_pkg::ST_FETCH) ||
                        (state_q == flash_crc_scanner_pkg::ST_FEED);
  assign FLASH_ADDR_O = addr_q[15:1];
  assign CPU_STALL_O  = FLASH_REQ_O | ~run_q;
  assign CPU_RUN_O    = run_q;
  assign NMI_O        = nmi_q;
  assign STATUS_O     = '{enable: enable_q, failure_nmi_enable: failure_nmi_enable_q,
                          scan_section_select: sel_q, busy: busy_q, pass: pass_q};

endmodule // flash_crc_scanner

// File: tb/flash_crc_scanner_checker.sv
// Purpose: Port-level checks of the flash checksum scanner
// Assumes: One clock domain, async high reset
// Notes: Attached to the top module by bind
`timescale 1ns/1ps
`include "flash_crc_scanner_defs.svh"

module flash_crc_scanner_checker (
  input wire logic                                  CORE_CLK_I,    // Core clock
  input wire logic                                  RESET_I,       // System reset
  input wire flash_crc_scanner_pkg::fuse_cfg_type   FUSE_CFG_I,    // Fuse settings
  input wire flash_crc_scanner_pkg::ctrl_write_type CTRL_WR_I,     // Control write
  input wire logic                                  SEL_WR_I,      // Section write
  input wire logic [1:0]                            SEL_VALUE_I,   // Section value
  input wire logic [15:0]                           FLASH_RDATA_I, // Flash word
  input wire logic                                  FLASH_REQ_O,   // Flash owned
  input wire logic [14:0]                           FLASH_ADDR_O,  // Word address
  input wire logic                                  CPU_STALL_O,   // CPU stalled
  input wire logic                                  CPU_RUN_O,     // CPU released
  input wire logic                                  NMI_O,         // Failure interrupt
  input wire flash_crc_scanner_pkg::scan_status_type STATUS_O      // Status
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I);
  // ****************************************
  // Helpers
  // ****************************************
  wire logic soft_wr = CTRL_WR_I.wr && CTRL_WR_I.soft_reset;  // Scanner reset write
  wire logic go = CTRL_WR_I.wr && CTRL_WR_I.enable && !CTRL_WR_I.soft_reset && !STATUS_O.busy && !NMI_O;
  sequence s_delay;  // Three-cycle launch, CPU still running
    STATUS_O.busy && !FLASH_REQ_O && !CPU_STALL_O ##1 !FLASH_REQ_O && !CPU_STALL_O ##1 FLASH_REQ_O && CPU_STALL_O;
  endsequence
  sequence s_word;  // Address held for one word period
    $stable(FLASH_ADDR_O) [*4];
  endsequence
  // ****************************************
  // Assertions
  // ****************************************
  AST_START_DELAY: assert property (go |=> s_delay) else $error("scan launch timing wrong");
  AST_FETCH_LEN: assert property (STATUS_O.busy && $changed(FLASH_ADDR_O) |=> s_word)
    else $error("word period too short");
  AST_STALL: assert property (FLASH_REQ_O |-> CPU_STALL_O) else $error("CPU not stalled");
  AST_GATE: assert property (!CPU_RUN_O |-> CPU_STALL_O) else $error("CPU runs ungated");
  AST_HANG: assert property ($fell(STATUS_O.busy) && !STATUS_O.pass && !CPU_RUN_O |=> !CPU_RUN_O [*8])
    else $error("CPU released after failure");
  AST_NMI_FIRE: assert property ($fell(STATUS_O.busy) && !STATUS_O.pass && STATUS_O.failure_nmi_enable |-> NMI_O)
    else $error("failure interrupt missing");
  AST_NMI_CAUSE: assert property ($rose(NMI_O) |-> STATUS_O.failure_nmi_enable && !STATUS_O.pass)
    else $error("interrupt without failure");
  AST_NMI_STICKY: assert property (NMI_O |=> NMI_O) else $error("interrupt dropped");
  AST_FAILURE_NMI_ENABLE_STICKY: assert property (STATUS_O.failure_nmi_enable |=> STATUS_O.failure_nmi_enable)
    else $error("interrupt enable cleared");
  AST_ENABLE_HOLD: assert property (STATUS_O.enable && !soft_wr |=> STATUS_O.enable)
    else $error("enable cleared");
  AST_SEL_LOCK: assert property ((STATUS_O.busy || NMI_O) && !soft_wr |=> $stable(STATUS_O.scan_section_select))
    else $error("section changed while locked");
  AST_SEL_CODE: assert property (STATUS_O.scan_section_select != `SEL_RESERVED)
    else $error("reserved section code");
endmodule // flash_crc_scanner_checker

bind flash_crc_scanner flash_crc_scanner_checker u_chk (.CORE_CLK_I, .RESET_I, .FUSE_CFG_I, .CTRL_WR_I,
  .SEL_WR_I, .SEL_VALUE_I, .FLASH_RDATA_I, .FLASH_REQ_O, .FLASH_ADDR_O, .CPU_STALL_O, .CPU_RUN_O, .NMI_O, .STATUS_O);

// File: tb/flash_crc_scanner_tb_top.sv
// Purpose: Self-checking bench of the flash checksum scanner
// Assumes: Inputs driven at the falling edge
// Notes: Sections end at bytes 15, 31 and 63
`timescale 1ns/1ps
`include "flash_crc_scanner_defs.svh"

module flash_crc_scanner_tb_top;
  logic                                   CORE_CLK_I = 1'b0; // Clock
  logic                                   RESET_I = 1'b1;    // Reset
  flash_crc_scanner_pkg::fuse_cfg_type    FUSE_CFG_I = {1'b0, 2'h0, 16'h000F, 16'h001F, 16'h003F};
  flash_crc_scanner_pkg::ctrl_write_type  CTRL_WR_I = '0;    // Control write
  logic                                   SEL_WR_I = 1'b0;   // Section write
  logic [1:0]                             SEL_VALUE_I = 2'h0; // Section value
  logic [15:0]                            FLASH_RDATA_I;     // From model
  logic                                   FLASH_REQ_O;       // Flash owned
  logic [14:0]                            FLASH_ADDR_O;      // Word address
  logic                                   CPU_STALL_O;       // CPU stalled
  logic                                   CPU_RUN_O;         // CPU released
  logic                                   NMI_O;             // Interrupt
  flash_crc_scanner_pkg::scan_status_type STATUS_O;          // Status
  integer num_errors = 0, tests_run = 0, seed = 4581, cyc = 0; // Counters

  flash_crc_scanner u_dut (.CORE_CLK_I, .RESET_I, .FUSE_CFG_I, .CTRL_WR_I, .SEL_WR_I, .SEL_VALUE_I,
    .FLASH_RDATA_I, .FLASH_REQ_O, .FLASH_ADDR_O, .CPU_STALL_O, .CPU_RUN_O, .NMI_O, .STATUS_O);
  flash_mem_model u_mem (.clk_i(CORE_CLK_I), .req_i(FLASH_REQ_O), .addr_i(FLASH_ADDR_O), .rdata_o(FLASH_RDATA_I));

  // ****************************************
  // Clock and hang guard
  // ****************************************
  initial forever #4 CORE_CLK_I = ~CORE_CLK_I;
  always @(posedge CORE_CLK_I) begin
    cyc++;
    if (cyc == 30000) begin  // Far beyond the planned run
      num_errors++;
      finish_test();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors=%0d checks=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Last byte of a section code
  function automatic int end_of(input logic [1:0] s);
    return (s == 2'h0) ? 63 : (s == 2'h1) ? 31 : 15;
  endfunction
  // Random content with checksum placed at the end, optionally corrupted
  task automatic fill(input int last, input logic good);
    logic [31:0] c;
    logic m32;
    m32 = FUSE_CFG_I.crc32_sel;
    for (int i = 0; i <= last; i++) u_mem.mem[i] = $random(seed);
    c = 32'hFFFFFFFF;
    for (int i = 0; i <= last - (m32 ? 4 : 2); i++) begin
      c ^= {24'h0, u_mem.mem[i]} << (m32 ? 24 : 8);
      for (int b = 0; b < 8; b++) c = (m32 ? c[31] : c[15]) ? (c << 1) ^ (m32 ? 32'h04C11DB7 : 32'h00001021) : c << 1;
    end
    if (m32) for (int k = 0; k < 4; k++) u_mem.mem[last - k] = c[31 - 8 * k -: 8];
    else {u_mem.mem[last - 1], u_mem.mem[last]} = c[15:0];
    if (!good) u_mem.mem[{$random(seed)} % (last + 1)] ^= 8'h5A;
  endtask
  task automatic do_reset(input logic m32, input logic [1:0] fz);
    @(negedge CORE_CLK_I);
    RESET_I = 1'b1;
    FUSE_CFG_I.crc32_sel = m32;
    FUSE_CFG_I.startup_scan_fuse_field = fz;
    repeat (20) @(negedge CORE_CLK_I);
    RESET_I = 1'b0;
    repeat (2) @(negedge CORE_CLK_I);
  endtask
  task automatic wr_sel(input logic [1:0] v);
    SEL_WR_I = 1'b1;
    SEL_VALUE_I = v;
    @(negedge CORE_CLK_I);
    SEL_WR_I = 1'b0;
    @(negedge CORE_CLK_I);
  endtask
  task automatic wr_ctl(input logic en, input logic nmi, input logic sr);
    CTRL_WR_I = {1'b1, en, nmi, sr};
    @(negedge CORE_CLK_I);
    CTRL_WR_I = '0;
    @(negedge CORE_CLK_I);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 400 && STATUS_O.busy !== 1'b0; i++) @(negedge CORE_CLK_I);
  endtask
  // Full scan of one section; section first, then enable
  task automatic scan(input logic [1:0] s, input logic good);
    fill(end_of(s), good);
    wr_sel(s);
    wr_ctl(1'b1, 1'b0, 1'b0);
    chk(STATUS_O.busy, 1'b1);
    wait_idle();
    chk({STATUS_O.busy, STATUS_O.pass}, {1'b0, good});
    chk({STATUS_O.enable, STATUS_O.scan_section_select}, {1'b1, s});
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    do_reset(1'b0, `BOOTSCAN_NONE);
    chk({STATUS_O, CPU_RUN_O, NMI_O}, 8'h03 << 1);
    $display("test reset done");
    for (int m = 0; m < 2; m++) begin
      do_reset(m[0], `BOOTSCAN_NONE);
      for (int s = 0; s < 3; s++) begin
        scan(s[1:0], 1'b1);
        scan(s[1:0], 1'b0);
      end
      $display("test scans mode %0d done", m);
    end
    wr_sel(`SEL_RESERVED);
    chk(STATUS_O.scan_section_select, `SEL_BOOT_ONLY);
    wr_ctl(1'b0, 1'b0, 1'b0);
    chk({STATUS_O.enable, STATUS_O.busy}, 2'h2);
    fill(15, 1'b1);
    wr_ctl(1'b1, 1'b0, 1'b0);
    wr_sel(`SEL_WHOLE_FLASH);
    chk(STATUS_O.scan_section_select, `SEL_BOOT_ONLY);
    wait_idle();
    wr_ctl(1'b0, 1'b1, 1'b0);
    chk(STATUS_O.failure_nmi_enable, 1'b1);
    scan(`SEL_BOOT_ONLY, 1'b0);
    chk(NMI_O, 1'b1);
    wr_sel(`SEL_BOOT_APP);
    wr_ctl(1'b0, 1'b0, 1'b1);
    chk({NMI_O, STATUS_O.failure_nmi_enable, STATUS_O.scan_section_select}, 4'hE);
    $display("test refusals done");
    for (int g = 3; g >= 1; g--) begin
      fill(end_of(2'(3 - g)), g > 1);
      do_reset(1'b1, g[1:0]);
      wait_idle();
      repeat (20) @(negedge CORE_CLK_I);
      chk(CPU_RUN_O, g > 1);
      chk({STATUS_O.enable, STATUS_O.scan_section_select, STATUS_O.pass}, {1'b1, 2'(3 - g), g > 1});
    end
    $display("test start-up done");
    finish_test();
  end
endmodule // flash_crc_scanner_tb_top

// File: tb/flash_mem_model.sv
// Purpose: Program flash seen from the scanner port
// Assumes: Byte store loaded by the bench
// Notes: Released port shows a toggling word, never the last one
`timescale 1ns/1ps

module flash_mem_model (
  input  wire logic        clk_i,   // Core clock
  input  wire logic        req_i,   // Scanner owns port
  input  wire logic [14:0] addr_i,  // Word address
  output logic      [15:0] rdata_o  // Read word
);
  logic [7:0]  mem [0:63];     // Byte store
  logic [15:0] last_q = 16'h0; // Word seen last cycle
  wire  [15:0] word = {mem[{addr_i[4:0], 1'b1}], mem[{addr_i[4:0], 1'b0}]}; // Even byte low
  // Remember the bus so a released port keeps changing
  always_ff @(posedge clk_i) last_q <= rdata_o;
  assign rdata_o = req_i ? word : ~last_q;
endmodule // flash_mem_model
